// ==== verilog/fnst_pkg.sv ====
/*
  Constants and carrier types for the synthesizer and tuning control block.
  Assumes an Avalon-MM master with 32-bit data and byte addressing.
*/
package fnst_pkg;

  // Register indices; byte address is index times four
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_CFG0 = 4'h1;
  localparam logic [3:0] IDX_UHI  = 4'h2;
  localparam logic [3:0] IDX_ULO  = 4'h3;
  localparam logic [3:0] IDX_LHI  = 4'h4;
  localparam logic [3:0] IDX_LLO  = 4'h5;
  localparam logic [3:0] IDX_LOAD = 4'h6;
  localparam logic [3:0] IDX_DIN  = 4'h7;
  localparam logic [3:0] IDX_EN   = 4'h8;
  localparam logic [3:0] IDX_STAT = 4'hc;

  // Field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_BW_BIT   = 4;
  localparam int CAP_W         = 5;
  localparam int STAT_TXRDY    = 1;
  localparam int STAT_DSM      = 3;
  localparam int STAT_NIB_LSB  = 4;

  // Word layout and divider offset
  localparam int INT_W  = 4;
  localparam int FRAC_W = 12;
  localparam int WORD_W = INT_W + FRAC_W;
  localparam int RATIO_W = WORD_W + 1;
  localparam logic [INT_W:0] DIV_OFFSET = 5'h10;

  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [CAP_W-1:0]  CAP_RST  = 5'h00;
  localparam logic              MODE_ASK = 1'b0;
  localparam logic              BW_300K  = 1'b0;

  // Software-written control settings
  typedef struct packed {
    logic             fsk_mode;
    logic             bw_wide;
    logic [CAP_W-1:0] cap_sel;
  } fnst_ctrl_t;

  // Settings presented to the analog synthesizer
  typedef struct packed {
    logic [RATIO_W-1:0] ratio;
    logic               dsm_on;
    logic               bw_wide;
  } fnst_synth_t;

endpackage : fnst_pkg

// ==== verilog/fnst_word_stage.sv ====
/*
  One frequency word: staging bytes plus the active copy.
  Assumes write and load strobes are single-cycle and synchronous.
*/
`timescale 1ns/1ps
module fnst_word_stage (
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic                        i_wr_hi,
  input  wire logic                        i_wr_lo,
  input  wire logic [7:0]                  i_wdata,
  input  wire logic                        i_load,
  output logic [fnst_pkg::WORD_W-1:0]      o_staged,
  output logic [fnst_pkg::WORD_W-1:0]      o_active
);

  // Staging bytes, then copy to active on load
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_staged <= fnst_pkg::WORD_RST;
      o_active <= fnst_pkg::WORD_RST;
    end else begin
      if (i_wr_hi) o_staged[15:8] <= i_wdata;
      if (i_wr_lo) o_staged[7:0]  <= i_wdata;
      if (i_load)  o_active <= o_staged;
    end
  end

endmodule : fnst_word_stage

// ==== verilog/fnst_square_gen.sv ====
/*
  Quarter-duty square wave from a phase accumulator stepped by the ratio.
  Assumes a single clock; output is low one clock after the run input is low, as it is registered.
*/
`timescale 1ns/1ps
module fnst_square_gen #(
  parameter int ACC_W = 20
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_reset,
  input  wire logic                         i_run,
  input  wire logic [fnst_pkg::RATIO_W-1:0] i_step,
  output logic                              o_drive
);

  logic [ACC_W-1:0] phase_r;
  logic [ACC_W-1:0] phase_nxt;

  // Advance phase by the divider ratio
  assign phase_nxt = phase_r + ACC_W'(i_step);

  // High in the first quarter of each cycle only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase_r <= '0;
      o_drive <= 1'b0;
    end else begin
      phase_r <= i_run ? phase_nxt : '0;
      o_drive <= i_run & (phase_nxt[ACC_W-1 -: 2] == 2'b00);
    end
  end

endmodule : fnst_square_gen

// ==== verilog/fnst_ctrl.sv ====
/*
  Control logic of a fractional-N transmit synthesizer with antenna tuning.
  Registers are reached over Avalon-MM with one wait state per access.
  Assumes all inputs are synchronous to i_clk.
*/
// Summary of operation
// [R1] Each set capacitor bit adds its binary weight, 0.25 pF up to 4.0 pF.
// [R2] The five-bit select gives 32 settings from zero to 7.75 pF.
// [R3] The bandwidth bit picks 300 kHz when clear and 600 kHz when set.
// [R4] Each divider word has a 4-bit integer and a 12-bit fraction.
// [R5] Words hold ratio minus 16 times 4096; the device adds 16 back.
// [R6] Amplitude-keyed mode uses only the lower word as carrier.
// [R7] Frequency-keyed mode switches between upper and lower words.
// [R8] The host keeps words between 0x2F42 and 0xC05A inclusive.
// [R9] With all fractions zero the delta-sigma path is held off.
// [R10] The host should pick 600 kHz when only integer division is used.
// [R11] Writing 1 to the load strobe applies the words; it self-clears.
// [R12] The drive is a 25 percent duty square wave from the synthesizer.
// [R13] The mode bit resets to amplitude keying; 1 selects frequency keying.
// [R14] In frequency keying, data high picks upper and low picks lower.
// [R15] In amplitude keying, data high enables drive and low disables it.
// [R16] Bytes are staged and both words go active together on load.
`timescale 1ns/1ps
module fnst_ctrl #(
  parameter int ACC_W = 20
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_reset,
  input  wire logic [5:0]                   i_address,
  input  wire logic                         i_read,
  input  wire logic                         i_write,
  input  wire logic [31:0]                  i_writedata,
  input  wire logic [3:0]                   i_byteenable,
  output logic [31:0]                       o_readdata,
  output logic                              o_waitrequest,
  input  wire logic                         i_mod_data,
  input  wire logic                         i_enable,
  output logic [fnst_pkg::CAP_W-1:0]        o_cap_sel,
  output fnst_pkg::fnst_synth_t             o_synth,
  output logic                              o_amp_output
);

  // Register state
  fnst_pkg::fnst_ctrl_t  ctrl_r;
  logic                  datain_r;
  logic                  enable_r;
  logic                  load_r;
  logic                  wait_r;
  logic [31:0]           readdata_r;
  fnst_pkg::fnst_synth_t synth_r;
  logic [fnst_pkg::CAP_W-1:0] cap_r;

  // Bus decode
  wire        req;
  wire        accept;
  wire        addr_ok;
  wire [3:0]  idx;
  wire        wr_go;
  wire        lane0;
  wire [7:0]  wbyte;

  assign req     = i_read | i_write;
  assign accept  = req & ~wait_r;
  assign addr_ok = (i_address[1:0] == 2'b00);
  assign idx     = i_address[5:2];
  assign lane0   = i_byteenable[0];
  assign wr_go   = i_write & accept & addr_ok & lane0;
  assign wbyte   = i_writedata[7:0];

  // Per-register selects
  wire sel_ctrl;
  wire sel_cfg0;
  wire sel_uhi;
  wire sel_ulo;
  wire sel_lhi;
  wire sel_llo;
  wire sel_load;
  wire sel_din;
  wire sel_en;
  wire sel_stat;

  assign sel_ctrl = (idx == fnst_pkg::IDX_CTRL);
  assign sel_cfg0 = (idx == fnst_pkg::IDX_CFG0);
  assign sel_uhi  = (idx == fnst_pkg::IDX_UHI);
  assign sel_ulo  = (idx == fnst_pkg::IDX_ULO);
  assign sel_lhi  = (idx == fnst_pkg::IDX_LHI);
  assign sel_llo  = (idx == fnst_pkg::IDX_LLO);
  assign sel_load = (idx == fnst_pkg::IDX_LOAD);
  assign sel_din  = (idx == fnst_pkg::IDX_DIN);
  assign sel_en   = (idx == fnst_pkg::IDX_EN);
  assign sel_stat = (idx == fnst_pkg::IDX_STAT);

  // Load strobe on a write of 1
  wire load_go;
  assign load_go = wr_go & sel_load & wbyte[0]; // R11

  // Two frequency words, staged then committed together
  logic [fnst_pkg::WORD_W-1:0] up_staged;
  logic [fnst_pkg::WORD_W-1:0] up_active;
  logic [fnst_pkg::WORD_W-1:0] lo_staged;
  logic [fnst_pkg::WORD_W-1:0] lo_active;

  fnst_word_stage u_upper (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_wr_hi  (wr_go & sel_uhi),
    .i_wr_lo  (wr_go & sel_ulo),
    .i_wdata  (wbyte),
    .i_load   (load_go), // R16
    .o_staged (up_staged),
    .o_active (up_active)
  );

  fnst_word_stage u_lower (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_wr_hi  (wr_go & sel_lhi),
    .i_wr_lo  (wr_go & sel_llo),
    .i_wdata  (wbyte),
    .i_load   (load_go), // R16
    .o_staged (lo_staged),
    .o_active (lo_active)
  );

  // Effective modulation data and enable, pin or register
  wire mod_bit;
  wire tx_en;
  assign mod_bit = i_mod_data | datain_r;
  assign tx_en   = i_enable | enable_r;

  // Word selection by mode and data
  wire                        pick_upper;
  wire [fnst_pkg::WORD_W-1:0] word_sel;
  assign pick_upper = ctrl_r.fsk_mode & mod_bit; // R6 R7 R14
  assign word_sel   = pick_upper ? up_active : lo_active; // R7

  // Divide ratio with the fixed offset added back
  wire [fnst_pkg::INT_W:0]     ratio_int;
  wire [fnst_pkg::RATIO_W-1:0] ratio_nxt;
  assign ratio_int = (fnst_pkg::INT_W + 1)'(word_sel[15:12])
                     + fnst_pkg::DIV_OFFSET; // R5
  assign ratio_nxt = {ratio_int, word_sel[11:0]}; // R4

  // Delta-sigma runs only with a non-zero fraction
  wire dsm_nxt;
  assign dsm_nxt = (|up_active[11:0]) | (|lo_active[11:0]); // R9

  // Drive gating: data keys the drive in amplitude mode
  wire amp_run;
  assign amp_run = tx_en & (ctrl_r.fsk_mode | mod_bit); // R15

  // Status byte
  wire [7:0] stat_byte;
  assign stat_byte = {word_sel[15:12], synth_r.dsm_on, 1'b0,
                      tx_en, 1'b0};

  // Read multiplexer; unmapped or misaligned reads give zero
  wire [7:0] rbyte;
  assign rbyte =
    !addr_ok ? 8'h00 :
    sel_ctrl ? {3'h0, ctrl_r.bw_wide, 3'h0, ctrl_r.fsk_mode} :
    sel_cfg0 ? {3'h0, ctrl_r.cap_sel} :
    sel_uhi  ? up_staged[15:8] :
    sel_ulo  ? up_staged[7:0] :
    sel_lhi  ? lo_staged[15:8] :
    sel_llo  ? lo_staged[7:0] :
    sel_load ? {7'h00, load_r} :
    sel_din  ? {7'h00, datain_r} :
    sel_en   ? {7'h00, enable_r} :
    sel_stat ? stat_byte :
    8'h00;

  // One wait state, then accept
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  // Read data captured during the wait state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      readdata_r <= 32'h0000_0000;
    end else if (i_read & wait_r) begin
      readdata_r <= {24'h00_0000, rbyte};
    end
  end

  // Control register and capacitor select
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r.fsk_mode <= fnst_pkg::MODE_ASK; // R13
      ctrl_r.bw_wide  <= fnst_pkg::BW_300K;
      ctrl_r.cap_sel  <= fnst_pkg::CAP_RST;
    end else begin
      if (wr_go & sel_ctrl) begin
        ctrl_r.fsk_mode <= wbyte[fnst_pkg::CTRL_MODE_BIT]; // R13
        ctrl_r.bw_wide  <= wbyte[fnst_pkg::CTRL_BW_BIT]; // R3
      end
      if (wr_go & sel_cfg0) begin
        ctrl_r.cap_sel <= wbyte[fnst_pkg::CAP_W-1:0]; // R2
      end
    end
  end

  // Data, enable and self-clearing load bits
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      datain_r <= 1'b0;
      enable_r <= 1'b0;
      load_r   <= 1'b0;
    end else begin
      if (wr_go & sel_din) datain_r <= wbyte[0];
      if (wr_go & sel_en)  enable_r <= wbyte[0];
      load_r <= load_go; // R11
    end
  end

  // Capacitor switches: bit n adds 0.25 pF times two to the n
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cap_r <= fnst_pkg::CAP_RST;
    end else begin
      cap_r <= ctrl_r.cap_sel; // R1
    end
  end

  // Synthesizer settings
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      synth_r <= '0;
    end else begin
      synth_r.ratio   <= ratio_nxt; // R5
      synth_r.dsm_on  <= dsm_nxt; // R9
      synth_r.bw_wide <= ctrl_r.bw_wide; // R3
    end
  end

  // Quarter-duty drive from the synthesized ratio
  fnst_square_gen #(
    .ACC_W (ACC_W)
  ) u_drive (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_run   (amp_run), // R15
    .i_step  (synth_r.ratio),
    .o_drive (o_amp_output) // R12
  );

  // Outputs straight from flops
  assign o_readdata    = readdata_r;
  assign o_waitrequest = wait_r;
  assign o_cap_sel     = cap_r;
  assign o_synth       = synth_r;

endmodule : fnst_ctrl

// ==== verification/fnst_ctrl_assertions.sv ====
/* Port checker for the synthesizer control block.
   Assumes the bus timing and register map of the block's hand-over. */
`timescale 1ns/1ps
module fnst_ctrl_assertions #(
  parameter int ACC_W = 20
) (
  input wire logic                  i_clk,
  input wire logic                  i_reset,
  input wire logic [5:0]            i_address,
  input wire logic                  i_read,
  input wire logic                  i_write,
  input wire logic [31:0]           i_writedata,
  input wire logic [3:0]            i_byteenable,
  input wire logic [31:0]           o_readdata,
  input wire logic                  o_waitrequest,
  input wire logic [4:0]            o_cap_sel,
  input wire fnst_pkg::fnst_synth_t o_synth,
  input wire logic                  o_amp_output
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Accepted bus cycles
  wire wr_ok = i_write && !o_waitrequest && i_byteenable[0];
  wire rd_ok = i_read && !o_waitrequest;
  a_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!i_read && !i_write && $past(!i_read && !i_write) |-> o_waitrequest)
    else $error("waitrequest low at idle");
  a_rd_upper: assert property (o_readdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (rd_ok && (i_address > 6'h30 || i_address[1:0] != 2'h0)
    |-> o_readdata == 32'h00000000) else $error("unmapped read not zero");
  a_cap_follow: assert property (wr_ok && i_address == 6'h04 |-> ##2
    o_cap_sel == $past(i_writedata[4:0], 2)) else $error("cap select mismatch");
  a_bw_follow: assert property (wr_ok && i_address == 6'h00 |-> ##2
    o_synth.bw_wide == $past(i_writedata[4], 2)) else $error("bandwidth mismatch");
  a_ratio_offset: assert property (!$past(i_reset) |-> o_synth.ratio[16])
    else $error("divide offset missing");
  a_dsm_frac: assert property (o_synth.ratio[11:0] != 12'h000 |-> o_synth.dsm_on)
    else $error("fraction without modulator");
  c_drive: cover property ($rose(o_amp_output));
  c_dsm_off: cover property ($fell(o_synth.dsm_on));
  c_unmapped: cover property (rd_ok && i_address == 6'h24);
endmodule : fnst_ctrl_assertions

bind fnst_ctrl fnst_ctrl_assertions #(.ACC_W(ACC_W)) i_chk (.i_clk(i_clk),
  .i_reset(i_reset), .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_cap_sel(o_cap_sel), .o_synth(o_synth),
  .o_amp_output(o_amp_output));

// ==== verification/fnst_host_model.sv ====
/* Host bus master model, one Avalon request at a time.
   Assumes the bench pulses i_go while o_busy is low. */
`timescale 1ns/1ps
module fnst_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_go,
  input  wire logic        i_wr,
  input  wire logic [5:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [31:0] i_readdata,
  input  wire logic        i_waitrequest,
  output logic             o_read,
  output logic             o_write,
  output logic [5:0]       o_address,
  output logic [31:0]      o_writedata,
  output logic             o_busy,
  output logic [31:0]      o_rdata
);
  // Hold request until waitrequest low, then release and scramble
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_busy <= 1'b0;
      o_address <= 6'h00;
      o_writedata <= 32'h0000_0000;
      o_rdata <= 32'h0000_0000;
    end else if (!o_busy && i_go) begin
      o_busy <= 1'b1;
      o_read <= !i_wr;
      o_write <= i_wr;
      o_address <= i_addr;
      o_writedata <= {24'h000000, i_wdata};
    end else if (o_busy && !i_waitrequest) begin
      o_busy <= 1'b0;
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_rdata <= i_readdata;
      o_address <= ~o_address;
      o_writedata <= ~o_writedata;
    end
  end
endmodule : fnst_host_model

// ==== verification/tb_fracn_synth_tuning_control.sv ====
/* Self-checking bench for the synthesizer control block.
   Assumes the host model as bus master and fixed-seed stimulus. */
`timescale 1ns/1ps
module tb_fracn_synth_tuning_control;
  logic                  i_clk = 1'b0;
  logic                  rst = 1'b1, go = 1'b0, wr = 1'b0, mod = 1'b0, en = 1'b0;
  logic [5:0]            adr = 6'h00, av_adr;
  logic [7:0]            wd = 8'h00;
  logic [3:0]            be = 4'h1;
  logic                  av_rd, av_wr, av_wait, busy, amp;
  logic [31:0]           av_wd, av_rdat, mrd;
  logic [4:0]            cap;
  logic [15:0]           u, l;
  fnst_pkg::fnst_synth_t syn, prev;
  integer                seed = 32'h19449cbb;
  int                    err_total = 0, num_checks = 0, i, n, hi;
  // Clock
  always #25 i_clk = ~i_clk;
  fnst_ctrl i_dut (.i_clk(i_clk), .i_reset(rst), .i_address(av_adr), .i_read(av_rd),
    .i_write(av_wr), .i_writedata(av_wd), .i_byteenable(be), .o_readdata(av_rdat),
    .o_waitrequest(av_wait), .i_mod_data(mod), .i_enable(en), .o_cap_sel(cap),
    .o_synth(syn), .o_amp_output(amp));
  fnst_host_model i_host (.i_clk(i_clk), .i_reset(rst), .i_go(go), .i_wr(wr),
    .i_addr(adr), .i_wdata(wd), .i_readdata(av_rdat), .i_waitrequest(av_wait),
    .o_read(av_rd), .o_write(av_wr), .o_address(av_adr), .o_writedata(av_wd),
    .o_busy(busy), .o_rdata(mrd));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // One bus access, bounded wait
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge i_clk); go <= 1'b1; wr <= w; adr <= a; wd <= d;
    @(posedge i_clk); go <= 1'b0;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk); #1;
      if (busy === 1'b0) break;
    end
    if (k == 20) begin err_total++; end_of_test(); end
  endtask : acc
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(mrd, {24'h000000, e});
  endtask : rdchk
  task automatic settle;
    repeat (2) @(posedge i_clk); #1;
  endtask : settle
  function automatic logic [16:0] xr(input logic [15:0] w);
    return {1'b0, w} + 17'h10000;
  endfunction : xr
  function automatic logic [15:0] rw;
    return 16'h2f42 + 16'($unsigned($random(seed)) % 32'h9119);
  endfunction : rw
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    rst <= 1'b0;
    settle();
    rdchk(6'h00, 8'h00);
    rdchk(6'h24, 8'h00);
    rdchk(6'h05, 8'h00);
    for (i = 0; i < 32; i++) begin
      acc(1'b1, 6'h04, 8'(i));
      settle();
      chk(cap, 32'(i));
    end
    // Write with lane 0 disabled must leave the switches alone
    @(posedge i_clk); be <= 4'h0;
    acc(1'b1, 6'h04, 8'h00); settle();
    chk(cap, 32'h0000_001f);
    @(posedge i_clk); be <= 4'h1;
    for (i = 0; i < 6; i++) begin
      u = (i == 0) ? 16'h2f42 : (i == 1) ? 16'h3001 : rw();
      l = (i == 0) ? 16'hc05a : (i == 1) ? 16'h5000 : rw();
      prev = syn;
      acc(1'b1, 6'h08, u[15:8]); acc(1'b1, 6'h0c, u[7:0]);
      acc(1'b1, 6'h10, l[15:8]); acc(1'b1, 6'h14, l[7:0]);
      settle();
      chk(syn, prev);
      rdchk(6'h0c, u[7:0]);
      acc(1'b1, 6'h18, 8'h01);
      settle();
      rdchk(6'h18, 8'h00);
      chk(syn.ratio, xr(l));
      chk(syn.dsm_on, (u[11:0] | l[11:0]) != 12'h000);
      rdchk(6'h30, {l[15:12], (u[11:0] | l[11:0]) != 12'h000, 3'h0});
      acc(1'b1, 6'h00, 8'h01); @(posedge i_clk); mod <= 1'b1; settle();
      chk(syn.ratio, xr(u));
      @(posedge i_clk); mod <= 1'b0; settle();
      chk(syn.ratio, xr(l));
      acc(1'b1, 6'h00, 8'h00); @(posedge i_clk); mod <= 1'($random(seed)); settle();
      chk(syn.ratio, xr(l));
    end
    u = 16'h3000; l = 16'h5000;
    acc(1'b1, 6'h08, u[15:8]); acc(1'b1, 6'h0c, u[7:0]);
    acc(1'b1, 6'h10, l[15:8]); acc(1'b1, 6'h14, l[7:0]);
    acc(1'b1, 6'h18, 8'h01); acc(1'b1, 6'h00, 8'h10); settle();
    chk(syn.dsm_on, 1'b0);
    chk(syn.bw_wide, 1'b1);
    acc(1'b1, 6'h00, 8'h00); settle();
    chk(syn.bw_wide, 1'b0);
    @(posedge i_clk); en <= 1'b1; mod <= 1'b0; hi = 0;
    for (n = 0; n < 32; n++) begin @(posedge i_clk); #1; hi += (amp === 1'b1); end
    chk(hi, 0);
    @(posedge i_clk); mod <= 1'b1; settle(); hi = 0;
    for (n = 0; n < 256; n++) begin @(posedge i_clk); #1; hi += (amp === 1'b1); end
    chk(hi >= 56 && hi <= 72, 1'b1);
    // Same drive keyed through the enable and data-in register bits
    @(posedge i_clk); en <= 1'b0; mod <= 1'b0;
    acc(1'b1, 6'h20, 8'h01); acc(1'b1, 6'h1c, 8'h01);
    rdchk(6'h20, 8'h01);
    rdchk(6'h1c, 8'h01);
    rdchk(6'h30, {l[15:12], 4'h2});
    hi = 0;
    for (n = 0; n < 64; n++) begin @(posedge i_clk); #1; hi += (amp === 1'b1); end
    chk(hi >= 10 && hi <= 22, 1'b1);
    end_of_test();
  end
endmodule : tb_fracn_synth_tuning_control
